// File: logic/pcs_defines.vh
// Purpose: Constants for the pole-changing starter control block
// Assumes: 50 MHz system clock
// Notes:   Times are in ms; cycle counts are derived from the clock rate
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

`define PCS_CLK_KHZ       50000
`define PCS_DEAD_MS       100
`define PCS_CHECK_MS      200
`define PCS_STAR_MS       5000
`define PCS_TMR_W         28

// Process image offsets (command side written, monitoring side read)
`define PCS_ADDR_W        2
`define PCS_ADDR_BYTE0    2'h0
`define PCS_ADDR_BYTE1    2'h1
`define PCS_ADDR_WORD1    2'h2

// Monitoring byte 0 bit positions
`define PCS_ST_WARN       7
`define PCS_ST_FAULT      6
`define PCS_ST_LOCAL      5
`define PCS_ST_OVLD       3
`define PCS_ST_RUN        2
`define PCS_ST_OFF        1
// Monitoring byte 1: inputs 5..0 at bits 7..2, fast run at bit 1
`define PCS_ST_DI_LSB     2
`define PCS_ST_FAST       1

// Command byte 0 and byte 1 bit positions
`define PCS_CM_FRESET     6
`define PCS_CM_AUTO       5
`define PCS_CM_EMSTART    4
`define PCS_CM_RUN        2
`define PCS_CM_OFF        1
`define PCS_CM_AUX        7
`define PCS_CM_DCOUT      4
`define PCS_CM_FAST       1

// Digital input indices
`define PCS_DI_FB         0
`define PCS_DI_START2     3
`define PCS_DI_START1     4
`define PCS_DI_STOP       5
`define PCS_DI_N          6

// Fault output selection
`define PCS_FSEL_NONE     2'h0
`define PCS_FSEL_DC       2'h1
`define PCS_FSEL_AUX      2'h2

`define PCS_CUR_MAX       16'h0320

`endif

// File: logic/pcs_sync.v
// Purpose: Two-stage synchroniser for a group of level inputs
// Assumes: Single destination clock
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/100ps
module pcs_sync #(
  parameter WIDTH = 6
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] d_in,
  output reg  [WIDTH-1:0] q_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= {WIDTH{1'b0}};
      q_out  <= {WIDTH{1'b0}};
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule // pcs_sync

// File: logic/pcs_starter.v
// Purpose: Two-speed starter control with cyclic process data image
// Assumes: Master writes command bytes through addr/data/strobe
// Notes:   Star-delta sequencing shares the same relay outputs
// Functional notes
// - Pole mode: speed one energises first relay
// - Pole mode: speed two energises second relay
// - Optional contactor feedback supervision
// - Local inputs start speed one/two, stop
// - DC output, or aux output in pole mode only, selectable as fault
// - No voltage-dip handling in pole mode
// - Monitoring bytes 0 and 1 layout
// - Byte 1 bit 1 flags fast running
// - Word 1 carries current 0 to 800 percent
// - Byte 1 bit 4 drives DC output
// - Star-delta: star, delta, main relays
`timescale 1ns/100ps
`include "pcs_defines.vh"
module pcs_starter #(
  parameter DEAD_CYCLES  = `PCS_DEAD_MS * `PCS_CLK_KHZ,
  parameter CHECK_CYCLES = `PCS_CHECK_MS * `PCS_CLK_KHZ,
  parameter STAR_CYCLES  = `PCS_STAR_MS * `PCS_CLK_KHZ
) (
  input  wire                   clk_in,
  input  wire                   rstn_in,
  input  wire                   cmd_wr_in,
  input  wire [`PCS_ADDR_W-1:0] cmd_addr_in,
  input  wire [7:0]             cmd_data_in,
  input  wire [`PCS_DI_N-1:0]   dig_inputs_in,
  input  wire                   star_delta_mode_in,
  input  wire                   checkback_en_in,
  input  wire                   local_inputs_en_in,
  input  wire [1:0]             fault_out_sel_in,
  input  wire                   voltage_dip_en_in,
  input  wire                   overload_warn_in,
  input  wire                   ext_fault_in,
  input  wire [15:0]            current_pct_in,
  output reg                    speed_one_relay_out,
  output reg                    speed_two_relay_out,
  output reg                    aux_relay_output_out,
  output reg                    dc_switched_output_out,
  output reg                    voltage_dip_active_out,
  output reg  [7:0]             status_flags_out,
  output reg  [7:0]             status_inputs_out,
  output reg  [15:0]            motor_current_percent_out
);

  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_SLOW  = 6'h02;
  localparam [5:0] S_FAST  = 6'h04;
  localparam [5:0] S_GAP   = 6'h08;
  localparam [5:0] S_STAR  = 6'h10;
  localparam [5:0] S_DELTA = 6'h20;

  localparam [`PCS_TMR_W-1:0] DEAD_T  = DEAD_CYCLES[`PCS_TMR_W-1:0];
  localparam [`PCS_TMR_W-1:0] CHECK_T = CHECK_CYCLES[`PCS_TMR_W-1:0];
  localparam [`PCS_TMR_W-1:0] STAR_T  = STAR_CYCLES[`PCS_TMR_W-1:0];

  function rise;
    input now_v;
    input last_v;
    begin
      rise = now_v & ~last_v;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reset release and input sampling

  reg                  rst_meta_q;
  reg                  rst_n_q;
  wire [`PCS_DI_N-1:0] di_s;
  reg  [`PCS_DI_N-1:0] di_last_q;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  pcs_sync #(
    .WIDTH    (`PCS_DI_N)
  ) u_di_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_q),
    .d_in     (dig_inputs_in),
    .q_out    (di_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // Command image

  reg  [7:0] cmd0_q;
  reg  [7:0] cmd1_q;
  reg  [7:0] cmd0_last_q;
  reg  [7:0] cmd1_last_q;

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd0_q      <= 8'h00;
      cmd1_q      <= 8'h00;
      cmd0_last_q <= 8'h00;
      cmd1_last_q <= 8'h00;
      di_last_q   <= {`PCS_DI_N{1'b0}};
    end else begin
      if (cmd_wr_in && cmd_addr_in == `PCS_ADDR_BYTE0)
        cmd0_q <= cmd_data_in;
      if (cmd_wr_in && cmd_addr_in == `PCS_ADDR_BYTE1)
        cmd1_q <= cmd_data_in;
      cmd0_last_q <= cmd0_q;
      cmd1_last_q <= cmd1_q;
      di_last_q   <= di_s;
    end
  end

  // Bus commands act in auto mode, local pushbuttons otherwise
  wire auto_w  = cmd0_q[`PCS_CM_AUTO];
  wire local_w = ~auto_w & local_inputs_en_in;
  wire bus_one = auto_w & rise(cmd0_q[`PCS_CM_RUN], cmd0_last_q[`PCS_CM_RUN]);
  wire bus_two = auto_w & rise(cmd1_q[`PCS_CM_FAST],
                               cmd1_last_q[`PCS_CM_FAST]);
  wire loc_one = local_w & rise(di_s[`PCS_DI_START1],
                                di_last_q[`PCS_DI_START1]);
  wire loc_two = local_w & rise(di_s[`PCS_DI_START2],
                                di_last_q[`PCS_DI_START2]);
  // Stop is honoured from either place so a motor can always be halted
  wire stop_w  = rise(cmd0_q[`PCS_CM_OFF], cmd0_last_q[`PCS_CM_OFF]) |
                 (local_inputs_en_in &
                  rise(di_s[`PCS_DI_STOP], di_last_q[`PCS_DI_STOP]));
  wire req_one = bus_one | loc_one;
  wire req_two = (bus_two | loc_two) & ~star_delta_mode_in;
  wire f_reset = rise(cmd0_q[`PCS_CM_FRESET], cmd0_last_q[`PCS_CM_FRESET]);

  //////////////////////////////////////////////////////////////////////////
  // Speed sequencer

  reg [5:0]            state_q;
  reg [5:0]            state_d;
  reg [5:0]            target_q;
  reg [5:0]            target_d;
  reg [`PCS_TMR_W-1:0] tmr_q;
  reg [`PCS_TMR_W-1:0] tmr_d;
  reg [`PCS_TMR_W-1:0] chk_q;
  reg                  fault_q;
  wire                 chk_trip;

  always @* begin
    state_d  = state_q;
    target_d = target_q;
    tmr_d    = tmr_q;
    if (tmr_q != {`PCS_TMR_W{1'b0}})
      tmr_d = tmr_q - {{(`PCS_TMR_W-1){1'b0}}, 1'b1};
    if (stop_w || fault_q) begin
      state_d = S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (req_two) begin
            state_d = S_FAST;
          end else if (req_one && star_delta_mode_in) begin
            state_d = S_STAR;
            tmr_d   = STAR_T;
          end else if (req_one) begin
            state_d = S_SLOW;
          end
        end
        S_SLOW: begin
          if (req_two) begin
            state_d  = S_GAP;
            target_d = S_FAST;
            tmr_d    = DEAD_T;
          end
        end
        S_FAST: begin
          if (req_one) begin
            state_d  = S_GAP;
            target_d = S_SLOW;
            tmr_d    = DEAD_T;
          end
        end
        S_STAR: begin
          if (tmr_q == {`PCS_TMR_W{1'b0}}) begin
            state_d  = S_GAP;
            target_d = S_DELTA;
            tmr_d    = DEAD_T;
          end
        end
        S_GAP: begin
          if (tmr_q == {`PCS_TMR_W{1'b0}})
            state_d = target_q;
        end
        S_DELTA: begin
          state_d = S_DELTA;
        end
        default: begin
          state_d = S_IDLE;
        end
      endcase
    end
  end

  wire run_d   = (state_d != S_IDLE);
  wire fast_d  = (state_d == S_FAST);
  wire relay0  = (state_d == S_SLOW) | (state_d == S_STAR);
  wire relay1  = (state_d == S_FAST) | (state_d == S_DELTA);
  wire main_on = star_delta_mode_in & run_d;
  // Feedback should follow the energised contactors
  wire expect_fb = speed_one_relay_out | speed_two_relay_out |
                   (star_delta_mode_in & aux_relay_output_out);
  assign chk_trip = (chk_q == CHECK_T);

  //////////////////////////////////////////////////////////////////////////
  // Supervision and fault latch

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q  <= S_IDLE;
      target_q <= S_IDLE;
      tmr_q    <= {`PCS_TMR_W{1'b0}};
      chk_q    <= {`PCS_TMR_W{1'b0}};
      fault_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      target_q <= target_d;
      tmr_q    <= tmr_d;
      // Mismatch must persist for the whole window before tripping
      if (!checkback_en_in || di_s[`PCS_DI_FB] == expect_fb || chk_trip)
        chk_q <= {`PCS_TMR_W{1'b0}};
      else
        chk_q <= chk_q + {{(`PCS_TMR_W-1){1'b0}}, 1'b1};
      // A new fault in the reset cycle still latches
      if ((checkback_en_in && chk_trip) || ext_fault_in)
        fault_q <= 1'b1;
      else if (f_reset)
        fault_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs and monitoring image

  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      speed_one_relay_out       <= 1'b0;
      speed_two_relay_out       <= 1'b0;
      aux_relay_output_out      <= 1'b0;
      dc_switched_output_out    <= 1'b0;
      voltage_dip_active_out    <= 1'b0;
      status_flags_out          <= 8'h00;
      status_inputs_out         <= 8'h00;
      motor_current_percent_out <= 16'h0000;
    end else begin
      speed_one_relay_out <= relay0 & ~relay1;
      speed_two_relay_out <= relay1 & ~relay0;
      if (star_delta_mode_in)
        aux_relay_output_out <= main_on;
      else if (fault_out_sel_in == `PCS_FSEL_AUX)
        aux_relay_output_out <= fault_q;
      else
        aux_relay_output_out <= cmd1_q[`PCS_CM_AUX];
      if (fault_out_sel_in == `PCS_FSEL_DC)
        dc_switched_output_out <= fault_q;
      else
        dc_switched_output_out <= cmd1_q[`PCS_CM_DCOUT];
      // Dip ride-through only exists in star-delta here
      voltage_dip_active_out <= voltage_dip_en_in &
                                star_delta_mode_in;
      status_flags_out <= 8'h00;
      status_flags_out[`PCS_ST_WARN]  <= overload_warn_in;
      status_flags_out[`PCS_ST_FAULT] <= fault_q;
      status_flags_out[`PCS_ST_LOCAL] <= ~auto_w;
      status_flags_out[`PCS_ST_OVLD]  <= overload_warn_in;
      status_flags_out[`PCS_ST_RUN]   <= run_d;
      status_flags_out[`PCS_ST_OFF]   <= ~run_d;
      status_inputs_out <= {di_s, 2'b00};
      status_inputs_out[`PCS_ST_FAST] <= fast_d &
                                         ~star_delta_mode_in;
      if (current_pct_in > `PCS_CUR_MAX)
        motor_current_percent_out <= `PCS_CUR_MAX;
      else
        motor_current_percent_out <= current_pct_in;
    end
  end

endmodule // pcs_starter

// File: testbench/pcs_starter_sva.sv
// Purpose: Port assertions for the two-speed starter
// Assumes: Dead time of 8 cycles, as set by the bench
// Notes:   Checks wait 7 cycles after reset for the internal release
`timescale 1ns/100ps
module pcs_starter_sva #(
  parameter DEAD_CYCLES = 8
) (
  input wire        clk_in,
  input wire        rstn_in,
  input wire        cmd_wr_in,
  input wire [1:0]  cmd_addr_in,
  input wire [7:0]  cmd_data_in,
  input wire [5:0]  dig_inputs_in,
  input wire        star_delta_mode_in,
  input wire [1:0]  fault_out_sel_in,
  input wire        ext_fault_in,
  input wire [15:0] current_pct_in,
  input wire        speed_one_relay_out,
  input wire        speed_two_relay_out,
  input wire        dc_switched_output_out,
  input wire        voltage_dip_active_out,
  input wire [7:0]  status_flags_out,
  input wire [7:0]  status_inputs_out,
  input wire [15:0] motor_current_percent_out
);
  reg  [2:0] up_q;
  wire       live;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  assign live = (up_q == 3'h7);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in || !live);
  sequence s_two_held_off;
    !speed_two_relay_out [*8];
  endsequence
  chk_speed_excl:
    assert property (!(speed_one_relay_out && speed_two_relay_out))
    else $error("both speed relays energised");
  chk_dead_gap:
    assert property ($fell(speed_one_relay_out) |-> s_two_held_off)
    else $error("speed two energised inside dead time");
  chk_cur_clamp:
    assert property (motor_current_percent_out ==
      ($past(current_pct_in) > 16'h0320 ? 16'h0320 : $past(current_pct_in)))
    else $error("current word wrong");
  chk_di_mirror:
    assert property (status_inputs_out[7:2] == $past(dig_inputs_in, 3))
    else $error("input mirror wrong");
  chk_fast_flag:
    assert property (!star_delta_mode_in && $rose(speed_two_relay_out)
      |-> ##[0:2] status_inputs_out[1])
    else $error("fast flag missing");
  chk_warn_copy:
    assert property (status_flags_out[7] == status_flags_out[3])
    else $error("summary warning differs from overload");
  chk_run_off:
    assert property (status_flags_out[2] |-> !status_flags_out[1])
    else $error("run and off both set");
  chk_dip_block:
    assert property (!$past(star_delta_mode_in) |-> !voltage_dip_active_out)
    else $error("dip active in pole mode");
  chk_dc_cmd:
    assert property (cmd_wr_in && cmd_addr_in == 2'h1 && cmd_data_in[4]
      && fault_out_sel_in == 2'h0 |-> ##[1:3] dc_switched_output_out)
    else $error("dc output ignores command");
  chk_fault_flag:
    assert property (ext_fault_in |-> ##[1:3] status_flags_out[6])
    else $error("fault flag missing");
endmodule // pcs_starter_sva
bind pcs_starter pcs_starter_sva #(.DEAD_CYCLES(DEAD_CYCLES)) u_chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .cmd_wr_in(cmd_wr_in),
  .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
  .dig_inputs_in(dig_inputs_in), .star_delta_mode_in(star_delta_mode_in),
  .fault_out_sel_in(fault_out_sel_in), .ext_fault_in(ext_fault_in),
  .current_pct_in(current_pct_in), .speed_one_relay_out(speed_one_relay_out),
  .speed_two_relay_out(speed_two_relay_out),
  .dc_switched_output_out(dc_switched_output_out),
  .voltage_dip_active_out(voltage_dip_active_out),
  .status_flags_out(status_flags_out), .status_inputs_out(status_inputs_out),
  .motor_current_percent_out(motor_current_percent_out));

// File: testbench/pcs_master_model.sv
// Purpose: Fieldbus master writing command bytes
// Assumes: One-cycle write strobe
// Notes:   Idle data shows the inverse so stale bytes are never reused
`timescale 1ns/100ps
module pcs_master_model (
  input  wire       clk_in,
  output reg        cmd_wr_out,
  output reg  [1:0] cmd_addr_out,
  output reg  [7:0] cmd_data_out
);
  initial begin
    cmd_wr_out = 1'b0;
    cmd_addr_out = 2'h0;
    cmd_data_out = 8'h00;
  end
  // Byte 0 holds reset/auto/run/off, byte 1 bit 1 asks for fast
  task put(input [1:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      #1;
      cmd_wr_out = 1'b1;
      cmd_addr_out = a;
      cmd_data_out = d;
      @(posedge clk_in);
      #1;
      cmd_wr_out = 1'b0;
      cmd_data_out = ~d;
    end
  endtask
endmodule // pcs_master_model

// File: testbench/pole_changing_starter_io_tb_top.sv
// Purpose: Self-checking bench for the two-speed starter
// Assumes: Short dead, check and star counts
// Notes:   Relay changes are compared against a queue of expected states
`timescale 1ns/100ps
module pole_changing_starter_io_tb_top;
  reg         clk_in = 1'b0;
  reg         rstn_in = 1'b0;
  reg  [5:0]  di = 6'h00;
  reg         ovl = 1'b0;
  reg         xflt = 1'b0;
  reg  [15:0] cur = 16'h0000;
  reg         sd = 1'b0;
  reg         ce = 1'b0;
  reg  [1:0]  fsel = 2'h0;
  reg  [7:0]  rnd = 8'h09;
  reg  [15:0] v;
  reg  [1:0]  prev = 2'b00;
  reg  [1:0]  expq[$];
  wire        wr, s1, s2, dco, aux, dip;
  wire [1:0]  adr;
  wire [7:0]  dat, sf, si;
  wire [15:0] mc;
  integer     n_errors = 0;
  integer     checks = 0;
  integer     i;
  always #10 clk_in = ~clk_in;
  pcs_master_model u_mst (.clk_in(clk_in), .cmd_wr_out(wr),
    .cmd_addr_out(adr), .cmd_data_out(dat));
  pcs_starter #(.DEAD_CYCLES(8), .CHECK_CYCLES(20), .STAR_CYCLES(30)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .cmd_wr_in(wr), .cmd_addr_in(adr),
    .cmd_data_in(dat), .dig_inputs_in(di), .star_delta_mode_in(sd),
    .checkback_en_in(ce), .local_inputs_en_in(1'b1),
    .fault_out_sel_in(fsel), .voltage_dip_en_in(1'b1),
    .overload_warn_in(ovl), .ext_fault_in(xflt), .current_pct_in(cur),
    .speed_one_relay_out(s1), .speed_two_relay_out(s2),
    .aux_relay_output_out(aux), .dc_switched_output_out(dco),
    .voltage_dip_active_out(dip), .status_flags_out(sf),
    .status_inputs_out(si), .motor_current_percent_out(mc));
  ////////////////////////////////////////////////////////////////
  function [7:0] lf(input [7:0] s);
    lf = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tk(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  // Queue the relay states on the way before the relays change to them
  task note(input [1:0] a, input [1:0] b);
    begin
      expq.push_back(a);
      if (b != a) expq.push_back(b);
    end
  endtask
  task settle(input [1:0] b);
    integer k;
    begin
      for (k = 0; k < 60 && {s2, s1} !== b; k = k + 1) tk(1);
      tk(2);
    end
  endtask
  task want(input [1:0] a, input [1:0] b);
    begin
      note(a, b);
      settle(b);
    end
  endtask
  task pulse(input integer b);
    begin
      di[b] = 1'b1;
      tk(4);
      di[b] = 1'b0;
      tk(2);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Sampled mid-cycle so the relay registers have settled
  always @(negedge clk_in) begin
    if ({s2, s1} !== prev)
      chk({s2, s1}, expq.size() ? expq.pop_front() : 16'hffff);
    prev <= {s2, s1};
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors = n_errors + 1;
    test_done;
  end
  initial begin
    tk(20);
    rstn_in = 1'b1;
    tk(5);
    u_mst.put(2'h0, 8'h20);
    u_mst.put(2'h0, 8'h24);
    want(2'b01, 2'b01);
    chk(sf[2:1], 2'b10);
    u_mst.put(2'h1, 8'h02);
    want(2'b00, 2'b10);
    chk(si[1], 1'b1);
    u_mst.put(2'h0, 8'h22);
    want(2'b00, 2'b00);
    chk(sf[2:1], 2'b01);
    u_mst.put(2'h1, 8'h10);
    tk(3);
    chk(dco, 1'b1);
    u_mst.put(2'h1, 8'h00);
    tk(3);
    chk(dco, 1'b0);
    $display("bus control test done");
    u_mst.put(2'h0, 8'h00);
    tk(3);
    chk(sf[5], 1'b1);
    note(2'b01, 2'b01);
    pulse(4);
    settle(2'b01);
    note(2'b00, 2'b10);
    pulse(3);
    settle(2'b10);
    note(2'b00, 2'b00);
    pulse(5);
    settle(2'b00);
    $display("local input test done");
    for (i = 0; i < 8; i = i + 1) begin
      rnd = lf(rnd);
      di = {3'h0, rnd[2:0]};
      ovl = rnd[3];
      cur = {5'h00, rnd, 3'h0};
      tk(4);
      v = (cur > 16'h0320) ? 16'h0320 : cur;
      chk(si[7:2], di);
      chk(mc, v);
      chk({sf[7], sf[3]}, {ovl, ovl});
    end
    $display("monitoring test done");
    xflt = 1'b1;
    tk(3);
    chk(sf[6], 1'b1);
    xflt = 1'b0;
    u_mst.put(2'h0, 8'h40);
    tk(3);
    chk(sf[6], 1'b0);
    chk(expq.size(), 16'h0000);
    $display("fault test done");
    di = 6'h00;
    sd = 1'b1;
    u_mst.put(2'h0, 8'h20);
    chk(dip, 1'b1);
    note(2'b01, 2'b00);
    note(2'b10, 2'b10);
    u_mst.put(2'h0, 8'h24);
    tk(2);
    chk({aux, s2, s1}, 3'b101);
    settle(2'b10);
    chk({aux, si[1]}, 2'b10);
    note(2'b00, 2'b00);
    u_mst.put(2'h0, 8'h22);
    settle(2'b00);
    chk(aux, 1'b0);
    sd = 1'b0;
    tk(2);
    chk(dip, 1'b0);
    $display("star-delta test done");
    ce = 1'b1;
    note(2'b01, 2'b00);
    u_mst.put(2'h0, 8'h24);
    tk(4);
    settle(2'b00);
    chk(sf[6], 1'b1);
    fsel = 2'h1;
    tk(2);
    chk(dco, 1'b1);
    fsel = 2'h2;
    tk(2);
    chk({aux, dco}, 2'b10);
    ce = 1'b0;
    u_mst.put(2'h0, 8'h40);
    tk(3);
    chk({sf[6], aux}, 2'b00);
    fsel = 2'h1;
    u_mst.put(2'h1, 8'h10);
    tk(3);
    chk(dco, 1'b0);
    chk(expq.size(), 16'h0000);
    $display("fault output test done");
    test_done;
  end
endmodule // pole_changing_starter_io_tb_top
